/* File: nfs_pkg.sv */
/*
  Shared constants and types of the flash command sequencer: command
  codes, identifier offsets, status bits, read setup fields, states.
  Assumes 16-bit data words and word addressing on the bus.
*/
package nfs_pkg;
  // ==========================================================
  // Geometry
  localparam int AW        = 24;
  localparam int DW        = 16;
  localparam int BLK_AW    = 16;
  localparam int BUF_AW    = 9;
  localparam int BUF_WORDS = 512;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_RD_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_RD_IDENT  = 8'h90;
  localparam logic [7:0] CMD_RD_QUERY  = 8'h98;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STAT  = 8'h50;
  localparam logic [7:0] CMD_WORD_PGM  = 8'h40;
  localparam logic [7:0] CMD_BUF_PGM   = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM   = 8'hD0;
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_CFG_WRITE = 8'h03;
  // ==========================================================
  // Identifier space offsets
  localparam logic [15:0] OFS_MAKER     = 16'h0000;
  localparam logic [15:0] OFS_PART      = 16'h0001;
  localparam logic [15:0] OFS_PROTECT   = 16'h0002;
  localparam logic [15:0] OFS_RSETUP    = 16'h0005;
  localparam logic [15:0] OFS_GPR       = 16'h0007;
  localparam logic [15:0] OFS_OTP_LOCK0 = 16'h0080;
  localparam logic [15:0] OFS_OTP_LOCK1 = 16'h0089;
  localparam logic [15:0] OFS_OTP_END   = 16'h0109;
  // ==========================================================
  // Status word
  localparam int         SR_READY    = 7;
  localparam int         SR_SEQ      = 5;
  localparam int         SR_FAIL     = 4;
  localparam int         SR_SUPPLY   = 3;
  localparam int         SR_LOCK     = 1;
  localparam logic [7:0] SR_RESET    = 8'h80;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;
  // ==========================================================
  // Read setup register fields
  localparam int          RS_ASYNC   = 15;
  localparam int          RS_LAT_LSB = 11;
  localparam int          RS_LEN_LSB = 0;
  localparam logic [15:0] RS_RESET   = 16'h8000;
  localparam logic [2:0]  LEN_4      = 3'h1;
  localparam logic [2:0]  LEN_8      = 3'h2;
  localparam logic [2:0]  LEN_16     = 3'h3;
  localparam logic [4:0]  WORDS_4    = 5'h04;
  localparam logic [4:0]  WORDS_8    = 5'h08;
  localparam logic [4:0]  WORDS_16   = 5'h10;
  // ==========================================================
  // Types
  typedef struct packed {
    logic          ce_n;
    logic          addr_latch_n;
    logic          we_n;
    logic          oe_n;
    logic          bclk;
    logic          vpp_ok;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
  } nfs_pins_t;

  localparam nfs_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                      1'b0, 24'h000000, 16'h0000};

  typedef enum logic [3:0] {
    RM_ARRAY  = 4'h1,
    RM_IDENT  = 4'h2,
    RM_STATUS = 4'h4,
    RM_QUERY  = 4'h8
  } nfs_rmode_t;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_WP_DATA  = 8'h02,
    ST_CFG      = 8'h04,
    ST_BP_COUNT = 8'h08,
    ST_BP_DATA  = 8'h10,
    ST_PG_FETCH = 8'h20,
    ST_PG_CHECK = 8'h40,
    ST_PG_RUN   = 8'h80
  } nfs_state_e_t;
endpackage

/* File: nfs_wbuf.sv */
/*
  Write buffer of the buffered program sequence, one word per entry.
  Assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/10ps
module nfs_wbuf
  import nfs_pkg::*;
(
  // Clock
  input  wire logic              i_mclk,
  // Write port
  input  wire logic              i_we,
  input  wire logic [BUF_AW-1:0] i_waddr,
  input  wire logic [DW-1:0]     i_wdata,
  // Read port
  input  wire logic [BUF_AW-1:0] i_raddr,
  output logic      [DW-1:0]     o_rdata
);
  logic [DW-1:0] mem [BUF_WORDS];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // nfs_wbuf

/* File: nfs_seq.sv */
/*
  Command and bus-cycle sequencer of a parallel NOR flash: burst reads,
  identifier space, word and buffered programming, status reporting.
  Assumes array, lock bits, query and OTP data answer combinationally
  to o_arr_addr, and a program engine that pulses done when finished.
*/
// Functional notes
// - Burst reads run only after the read setup register is configured.
// - Burst transfers serve array, identifier, status and query reads.
// - Address latched on latch-strobe rising, or clock edge while low.
// - First word after configured latency, then one word per clock edge.
// - Non-array burst repeats the same word until length completes.
// - After read-query command, reads return query data until changed.
// - Identifier space gives maker code at 0x00, part code at 0x01.
// - Block base plus 0x02 shows lock in bit 0, lock-down in bit 1.
// - Read setup at 0x05, general word at 0x07, OTP words above.
// - Program to locked block aborts, sets fail and lock-fault bits.
// - Word program is setup write then address/data write.
// - Programming only clears array bits from one to zero.
// - After program command reads return status until next read command.
// - While busy ready bit is low; only read commands are taken.
// - End of word program reports fail, supply and lock faults.
// - Buffered setup sets ready bit to show buffer available.
// - Count then start address with data, all within start plus count.
// - Non-confirm after buffer data gives sequence error and fail.
// - Array write error stops programming, sets ready and fail.
// - Block crossing is sequence error; low supply sets supply fault.
// - Reset enters read-array state; read state changes by command.
`timescale 1ns/10ps
module nfs_seq
  import nfs_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A01, // Arbitrary value
  parameter logic [15:0] GP_WORD    = 16'h0000
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_reset_n,
  // Flash bus pins
  input  wire logic          i_ce_n,
  input  wire logic          i_addr_latch_n,
  input  wire logic          i_we_n,
  input  wire logic          i_oe_n,
  input  wire logic          i_bclk,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_dq,
  output logic      [DW-1:0] o_dq,
  output logic               o_dq_oe,
  input  wire logic          i_vpp_ok,
  // Array, lock, query and OTP read side
  output logic      [AW-1:0] o_arr_addr,
  input  wire logic [DW-1:0] i_arr_rdata,
  input  wire logic [1:0]    i_blk_lock,
  input  wire logic [DW-1:0] i_cfi_rdata,
  input  wire logic [DW-1:0] i_otp_rdata,
  // Program engine
  output logic               o_pgm_req,
  output logic      [AW-1:0] o_pgm_addr,
  output logic      [DW-1:0] o_pgm_data,
  input  wire logic          i_pgm_done,
  input  wire logic          i_pgm_err
);
  typedef struct packed {
    nfs_pins_t     s0;
    nfs_pins_t     s1;
    nfs_pins_t     p;
    nfs_state_e_t  state;
    nfs_rmode_t    rmode;
    logic [7:0]    sr;
    logic [15:0]   rs;
    logic          cfg_done;
    logic [DW-1:0] wp_data;
    logic          buf_mode;
    logic [AW-1:0] start;
    logic [8:0]    cnt;
    logic [8:0]    idx;
    logic [9:0]    loaded;
    logic [AW-1:0] arr_addr;
    logic          pgm_req;
    logic [AW-1:0] pgm_addr;
    logic [DW-1:0] pgm_data;
    logic          b_active;
    logic [3:0]    b_lat;
    logic [4:0]    b_left;
    logic          b_cont;
    logic [AW-1:0] b_addr;
    logic          stb_taken;
    logic [DW-1:0] dout;
  } nfs_seq_t;

  nfs_seq_t          q;
  nfs_seq_t          next_q;
  nfs_pins_t         pins;
  logic              wr;
  logic [7:0]        cmd;
  logic              sync_mode;
  logic              clk_rise;
  logic              stb_rise;
  logic              stb_fall;
  logic              latch;
  logic              pg_busy;
  logic [DW-1:0]     id_word;
  logic [DW-1:0]     rword;
  logic [DW-1:0]     src;
  logic [AW-1:0]     off;
  logic [AW-1:0]     last;
  logic              buf_we;
  logic [BUF_AW-1:0] buf_waddr;
  logic [DW-1:0]     buf_rdata;

  // ==========================================================
  // Helpers
  function automatic nfs_rmode_t rd_cmd(input logic [7:0] c,
                                        input nfs_rmode_t m);
    case (c)
      CMD_RD_ARRAY:  rd_cmd = RM_ARRAY;
      CMD_RD_IDENT:  rd_cmd = RM_IDENT;
      CMD_RD_QUERY:  rd_cmd = RM_QUERY;
      CMD_RD_STATUS: rd_cmd = RM_STATUS;
      default:       rd_cmd = m;
    endcase
  endfunction

  function automatic logic [4:0] burst_words(input logic [2:0] c);
    case (c)
      LEN_4:   burst_words = WORDS_4;
      LEN_8:   burst_words = WORDS_8;
      LEN_16:  burst_words = WORDS_16;
      default: burst_words = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // Pin sampling and strobe edges
  assign pins = '{i_ce_n, i_addr_latch_n, i_we_n, i_oe_n, i_bclk,
                  i_vpp_ok, i_addr, i_dq};
  assign wr        = !q.p.we_n && q.s1.we_n && !q.s1.ce_n;
  assign cmd       = q.p.dq[7:0];
  assign clk_rise  = q.s1.bclk && !q.p.bclk;
  assign stb_rise  = q.s1.addr_latch_n && !q.p.addr_latch_n;
  assign stb_fall  = !q.s1.addr_latch_n && q.p.addr_latch_n;
  assign sync_mode = q.cfg_done && !q.rs[RS_ASYNC];
  assign latch     = !q.stb_taken && (stb_rise ||
                     (clk_rise && !q.s1.addr_latch_n));
  assign pg_busy   = q.state inside {ST_PG_FETCH, ST_PG_CHECK,
                                     ST_PG_RUN};

  // ==========================================================
  // Read word selection
  always_comb begin
    id_word = 16'h0000;
    if (q.arr_addr == AW'(OFS_MAKER)) begin
      id_word = MAKER_CODE;
    end else if (q.arr_addr == AW'(OFS_PART)) begin
      id_word = PART_CODE;
    end else if (q.arr_addr == AW'(OFS_RSETUP)) begin
      id_word = q.rs;
    end else if (q.arr_addr == AW'(OFS_GPR)) begin
      id_word = GP_WORD;
    end else if (q.arr_addr >= AW'(OFS_OTP_LOCK0) &&
                 q.arr_addr <= AW'(OFS_OTP_END)) begin
      id_word = i_otp_rdata;
    end else if (q.arr_addr[BLK_AW-1:0] == OFS_PROTECT) begin
      id_word = {14'h0000, i_blk_lock};
    end
  end

  always_comb begin
    rword = i_arr_rdata;
    unique case (q.rmode)
      RM_ARRAY:  rword = i_arr_rdata;
      RM_STATUS: rword = {8'h00, q.sr};
      RM_QUERY:  rword = i_cfi_rdata;
      RM_IDENT:  rword = id_word;
    endcase
  end

  assign src  = q.buf_mode ? buf_rdata : q.wp_data;
  assign off  = q.p.addr - ((q.loaded == 10'h000) ? q.p.addr : q.start);
  assign last = q.start + AW'(q.cnt);

  // ==========================================================
  // Next state
  always_comb begin
    next_q         = q;
    next_q.s0      = pins;
    next_q.s1      = q.s0;
    next_q.p       = q.s1;
    next_q.pgm_req = 1'b0;
    buf_we         = 1'b0;
    buf_waddr      = off[BUF_AW-1:0];
    if (pg_busy && wr) begin
      next_q.rmode = rd_cmd(cmd, q.rmode);
    end
    unique case (q.state)
      ST_IDLE: begin
        if (wr) begin
          next_q.rmode = rd_cmd(cmd, q.rmode);
          case (cmd)
            CMD_CLR_STAT: begin
              next_q.sr = q.sr & ~SR_ERR_MASK;
            end
            CMD_WORD_PGM: begin
              next_q.state = ST_WP_DATA;
              next_q.rmode = RM_STATUS;
            end
            CMD_BUF_PGM: begin
              next_q.state = ST_BP_COUNT;
              next_q.rmode = RM_STATUS;
              next_q.sr[SR_READY] = 1'b1;
            end
            CMD_CFG_SETUP: begin
              next_q.state = ST_CFG;
            end
            default: begin
            end
          endcase
        end
      end
      ST_WP_DATA: begin
        if (wr) begin
          next_q.pgm_addr = q.p.addr;
          next_q.wp_data  = q.p.dq;
          next_q.buf_mode = 1'b0;
          next_q.sr[SR_READY] = 1'b0;
          next_q.state    = ST_PG_FETCH;
        end
      end
      ST_CFG: begin
        if (wr) begin
          if (cmd == CMD_CFG_WRITE) begin
            next_q.rs       = q.p.addr[15:0];
            next_q.cfg_done = 1'b1;
          end
          next_q.state = ST_IDLE;
        end
      end
      ST_BP_COUNT: begin
        if (wr) begin
          next_q.cnt    = q.p.dq[8:0];
          next_q.loaded = 10'h000;
          next_q.state  = ST_BP_DATA;
          if (q.p.dq[DW-1:BUF_AW] != '0) begin
            next_q.sr    = q.sr | 8'hB0;
            next_q.state = ST_IDLE;
          end
        end
      end
      ST_BP_DATA: begin
        if (wr) begin
          if (q.loaded == {1'b0, q.cnt} + 10'h001) begin
            next_q.state = ST_IDLE;
            if (cmd != CMD_CONFIRM || q.p.addr[AW-1:BLK_AW] !=
                q.start[AW-1:BLK_AW]) begin
              next_q.sr = q.sr | 8'hB0;
            end else if (last[AW-1:BLK_AW] !=
                         q.start[AW-1:BLK_AW]) begin
              next_q.sr = q.sr | 8'hB0;
            end else begin
              next_q.idx      = 9'h000;
              next_q.pgm_addr = q.start;
              next_q.buf_mode = 1'b1;
              next_q.sr[SR_READY] = 1'b0;
              next_q.state    = ST_PG_FETCH;
            end
          end else if (off > AW'(q.cnt)) begin
            next_q.sr    = q.sr | 8'hB0;
            next_q.state = ST_IDLE;
          end else begin
            if (q.loaded == 10'h000) begin
              next_q.start = q.p.addr;
            end
            buf_we        = 1'b1;
            next_q.loaded = q.loaded + 10'h001;
          end
        end
      end
      ST_PG_FETCH: begin
        next_q.state = ST_PG_CHECK;
      end
      ST_PG_CHECK: begin
        next_q.state = ST_IDLE;
        if (!q.s1.vpp_ok) begin
          next_q.sr = q.sr | 8'h98;
        end else if (i_blk_lock[0]) begin
          next_q.sr = q.sr | 8'h92;
        end else begin
          next_q.pgm_req  = 1'b1;
          next_q.pgm_data = src & i_arr_rdata;
          next_q.state    = ST_PG_RUN;
        end
      end
      ST_PG_RUN: begin
        if (i_pgm_done) begin
          next_q.state = ST_IDLE;
          next_q.sr[SR_READY] = 1'b1;
          if (i_pgm_err) begin
            next_q.sr[SR_FAIL] = 1'b1;
          end else if (q.buf_mode && q.idx != q.cnt) begin
            next_q.idx      = q.idx + 9'h001;
            next_q.pgm_addr = q.pgm_addr + AW'(1);
            next_q.sr[SR_READY] = 1'b0;
            next_q.state    = ST_PG_FETCH;
          end
        end
      end
    endcase

    // Burst read engine
    if (q.s1.ce_n || !sync_mode) begin
      next_q.b_active  = 1'b0;
      next_q.stb_taken = 1'b0;
      next_q.dout      = rword;
    end else begin
      if (stb_fall) begin
        next_q.stb_taken = 1'b0;
      end
      if (latch) begin
        next_q.stb_taken = 1'b1;
        next_q.b_active  = 1'b1;
        next_q.b_addr    = q.p.addr;
        next_q.b_lat     = q.rs[RS_LAT_LSB +: 4];
        next_q.b_left    = burst_words(q.rs[RS_LEN_LSB +: 3]);
        next_q.b_cont    = burst_words(q.rs[RS_LEN_LSB +: 3]) == '0;
      end else if (q.b_active && clk_rise) begin
        if (q.b_lat != 4'h0) begin
          next_q.b_lat = q.b_lat - 4'h1;
        end else begin
          next_q.dout   = rword;
          next_q.b_left = q.b_left - 5'h01;
          if (q.rmode == RM_ARRAY) begin
            next_q.b_addr = q.b_addr + AW'(1);
          end
          if (!q.b_cont && q.b_left == 5'h01) begin
            next_q.b_active = 1'b0;
          end
        end
      end
    end
    next_q.arr_addr = pg_busy ? q.pgm_addr :
                      (sync_mode ? q.b_addr : q.s1.addr);
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      q          <= '0;
      q.s0       <= PINS_IDLE;
      q.s1       <= PINS_IDLE;
      q.p        <= PINS_IDLE;
      q.state    <= ST_IDLE;
      q.rmode    <= RM_ARRAY;
      q.sr       <= SR_RESET;
      q.rs       <= RS_RESET;
    end else begin
      q <= next_q;
    end
  end

  nfs_wbuf u_wbuf (
    .i_mclk  (i_mclk),
    .i_we    (buf_we),
    .i_waddr (buf_waddr),
    .i_wdata (q.p.dq),
    .i_raddr (q.idx),
    .o_rdata (buf_rdata)
  );

  // ==========================================================
  // Outputs
  assign o_dq       = q.dout;
  assign o_dq_oe    = !q.s1.ce_n && !q.s1.oe_n && q.s1.we_n;
  assign o_arr_addr = q.arr_addr;
  assign o_pgm_req  = q.pgm_req;
  assign o_pgm_addr = q.pgm_addr;
  assign o_pgm_data = q.pgm_data;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  a_reset_read_array: assert property (
    $past(!i_reset_n) |-> q.rmode == RM_ARRAY && q.state == ST_IDLE
  ) else $error("reset did not return to read array");

  a_lock_abort: assert property (
    (q.state == ST_PG_CHECK && q.s1.vpp_ok && i_blk_lock[0]) |=>
      q.sr[SR_FAIL] && q.sr[SR_LOCK] && !o_pgm_req && q.state == ST_IDLE
  ) else $error("locked block program not refused");

  a_supply_fault: assert property (
    (q.state == ST_PG_CHECK && !q.s1.vpp_ok) |=>
      q.sr[SR_FAIL] && q.sr[SR_SUPPLY] && q.sr[SR_READY]
  ) else $error("low supply not reported");

  a_clear_only: assert property (
    o_pgm_req |-> (o_pgm_data & ~i_arr_rdata) == 16'h0000
  ) else $error("program data sets an erased bit");

  a_busy_ready: assert property (
    pg_busy |-> !q.sr[SR_READY]
  ) else $error("ready bit high while busy");

  a_status_reads: assert property (
    (q.state == ST_IDLE && wr && cmd == CMD_WORD_PGM) |=>
      q.rmode == RM_STATUS [*2]
  ) else $error("word program did not select status");

  a_buf_avail: assert property (
    (q.state == ST_IDLE && wr && cmd == CMD_BUF_PGM) |=>
      q.sr[SR_READY] && q.state == ST_BP_COUNT
  ) else $error("buffer availability not shown");

  a_seq_error: assert property (
    (q.state == ST_BP_DATA && wr && cmd != CMD_CONFIRM &&
     q.loaded == {1'b0, q.cnt} + 10'h001) |=>
      (q.sr & 8'hB0) == 8'hB0 && q.state == ST_IDLE
  ) else $error("missing confirm not flagged");

  a_clear_errors: assert property (
    (q.state == ST_IDLE && wr && cmd == CMD_CLR_STAT) |=>
      (q.sr & SR_ERR_MASK) == 8'h00
  ) else $error("clear status left an error bit");

  a_write_fail: assert property (
    (q.state == ST_PG_RUN && i_pgm_done && i_pgm_err) |=>
      q.sr[SR_READY] && q.sr[SR_FAIL] && q.state == ST_IDLE
  ) else $error("array write error not stopped");

  a_burst_gate: assert property (
    !sync_mode |=> !q.b_active
  ) else $error("burst active without setup");

  c_word_program: cover property (
    q.state == ST_PG_RUN && i_pgm_done && !q.buf_mode
  );
  c_buffer_program: cover property (
    q.state == ST_PG_RUN && q.buf_mode && q.idx != 9'h000
  );
  c_burst_word: cover property (
    q.b_active && clk_rise && q.b_lat == 4'h0
  );
endmodule // nfs_seq

/* File: nfs_host.sv */
/*
  Host bus model: word writes, single reads and burst reads.
  Assumes the device samples all pins on i_mclk rising edges.
*/
`timescale 1ns/10ps
module nfs_host
  import nfs_pkg::*;
(
  // Clock and data from device
  input  wire logic          i_mclk,
  input  wire logic [DW-1:0] i_dq,
  // Bus pins
  output nfs_pins_t          o_pins
);
  initial o_pins = PINS_IDLE;
  task automatic hold(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // ==========================================================
  // Write: data inverted once released
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    o_pins.addr <= a;
    o_pins.dq <= d;
    o_pins.ce_n <= 1'b0;
    o_pins.we_n <= 1'b0;
    hold(5);
    o_pins.we_n <= 1'b1;
    hold(5);
    o_pins.ce_n <= 1'b1;
    o_pins.dq <= ~d;
    hold(4);
  endtask
  // ==========================================================
  // Single read and burst read
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    o_pins.addr <= a;
    o_pins.ce_n <= 1'b0;
    o_pins.oe_n <= 1'b0;
    hold(10);
    q = i_dq;
    o_pins.ce_n <= 1'b1;
    o_pins.oe_n <= 1'b1;
    hold(4);
  endtask
  task automatic burst(input logic [AW-1:0] a,
                       output logic [DW-1:0] w[5]);
    o_pins.addr <= a;
    o_pins.ce_n <= 1'b0;
    o_pins.oe_n <= 1'b0;
    o_pins.addr_latch_n <= 1'b0;
    hold(4);
    o_pins.addr_latch_n <= 1'b1;
    hold(4);
    o_pins.addr <= ~a;
    for (int k = 0; k < 5; k++) begin
      o_pins.bclk <= 1'b1;
      hold(4);
      o_pins.bclk <= 1'b0;
      hold(4);
      w[k] = i_dq;
    end
    o_pins.ce_n <= 1'b1;
    o_pins.oe_n <= 1'b1;
    hold(4);
  endtask
endmodule // nfs_host

/* File: tb_top.sv */
/*
  Self-checking bench of the flash sequencer.
  Assumes the host model drives the pins; array and engine live here.
*/
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
  import nfs_pkg::*;
  typedef struct packed {
    logic [7:0]    cmd;
    logic [AW-1:0] addr;
    logic [DW-1:0] exp;
  } nfs_row_t;
  logic          i_mclk = 1'b0;
  logic          i_reset_n = 1'b0;
  logic          i_pgm_done = 1'b0;
  logic          pgm_err = 1'b0;
  logic          vpp_ok = 1'b1;
  logic [1:0]    lk = 2'b11;
  nfs_pins_t     pins;
  logic [DW-1:0] o_dq, q, o_pgm_data, w[5];
  logic [AW-1:0] o_arr_addr, o_pgm_addr;
  logic [DW-1:0] arr_rdata, cfi_rdata, otp_rdata;
  logic          o_dq_oe, o_pgm_req;
  int            errors = 0, n_compared = 0, reqs = 0, dly = 0, n;
  nfs_row_t rows [8] = '{
    '{8'h90, 24'h000000, 16'h1234},
    '{8'h90, 24'h000001, 16'h4321},
    '{8'h90, 24'h010002, 16'h0003},
    '{8'h90, 24'h000005, 16'h8000},
    '{8'h90, 24'h000007, 16'h0F0F},
    '{8'h90, 24'h000089, 16'h5AD3},
    '{8'h98, 24'h000004, 16'h3C38},
    '{8'hFF, 24'h000033, 16'hA5F0}};
  // Lock, supply ok, engine error, status after word program
  logic [11:0] prow [4] = '{12'h480, 12'hC92, 12'h098, 12'h690};
  always #25 i_mclk = ~i_mclk;
  // ==========================================================
  // Array side and program engine
  assign arr_rdata = o_arr_addr[15:0] ^ 16'hA5C3;
  assign cfi_rdata = o_arr_addr[15:0] ^ 16'h3C3C;
  assign otp_rdata = o_arr_addr[15:0] ^ 16'h5A5A;
  always @(posedge i_mclk) begin
    i_pgm_done <= 1'b0;
    if (o_pgm_req === 1'b1) begin
      reqs <= reqs + 1;
      dly <= 40;
    end else if (dly > 0) begin
      dly <= dly - 1;
      i_pgm_done <= (dly == 1);
    end
  end
  nfs_host nfs_host_i (.i_mclk(i_mclk), .i_dq(o_dq), .o_pins(pins));
  nfs_seq #(.MAKER_CODE(16'h1234), .PART_CODE(16'h4321),
            .GP_WORD(16'h0F0F)) nfs_seq_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce_n(pins.ce_n),
    .i_addr_latch_n(pins.addr_latch_n), .i_we_n(pins.we_n),
    .i_oe_n(pins.oe_n), .i_bclk(pins.bclk), .i_addr(pins.addr),
    .i_dq(pins.dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .i_vpp_ok(vpp_ok), .o_arr_addr(o_arr_addr),
    .i_arr_rdata(arr_rdata), .i_blk_lock(lk),
    .i_cfi_rdata(cfi_rdata), .i_otp_rdata(otp_rdata),
    .o_pgm_req(o_pgm_req), .o_pgm_addr(o_pgm_addr),
    .o_pgm_data(o_pgm_data), .i_pgm_done(i_pgm_done),
    .i_pgm_err(pgm_err));
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    nfs_host_i.wr(a, d);
  endtask
  task automatic st(input logic [7:0] e);
    nfs_host_i.rd(24'h00ABCD, q);
    `CHK("status", e, q[7:0])
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    errors++;
    report_and_stop;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    `CHK("oe_rst", 1'b0, o_dq_oe)
    i_reset_n <= 1'b1;
    nfs_host_i.hold(4);
    foreach (rows[i]) begin
      wr(24'h0, {8'h00, rows[i].cmd});
      nfs_host_i.rd(rows[i].addr, q);
      `CHK("row", rows[i].exp, q)
    end
    $display("read rows done");
    for (int i = 0; i < 4; i++) begin
      lk <= {1'b0, prow[i][11]};
      vpp_ok <= prow[i][10];
      pgm_err <= prow[i][9];
      n = reqs;
      wr(24'h000010, {8'h00, CMD_WORD_PGM});
      wr(24'h000010, 16'h0FF0);
      nfs_host_i.rd(24'h000777, q);
      `CHK("busy", !(prow[i][10] && !prow[i][11]), q[7])
      nfs_host_i.hold(40);
      `CHK("reqs", n + (prow[i][10] && !prow[i][11]), reqs)
      `CHK("paddr", 24'h000010, o_pgm_addr)
      `CHK("pdata", 16'h0FF0 & 16'hA5D3, o_pgm_data)
      st(prow[i][7:0]);
      wr(24'h0, {8'h00, CMD_CLR_STAT});
      st(8'h80);
    end
    $display("word program done");
    wr(24'h020000, {8'h00, CMD_BUF_PGM});
    nfs_host_i.rd(24'h020000, q);
    `CHK("bufready", 1'b1, q[7])
    wr(24'h020000, 16'h0000);
    wr(24'h020000, 16'h1111);
    wr(24'h020000, 16'h00FF);
    st(8'hB0);
    wr(24'h0, {8'h00, CMD_CLR_STAT});
    wr(24'h02FFFF, {8'h00, CMD_BUF_PGM});
    wr(24'h02FFFF, 16'h0001);
    wr(24'h02FFFF, 16'h2222);
    wr(24'h030000, 16'h3333);
    wr(24'h02FFFF, {8'h00, CMD_CONFIRM});
    st(8'hB0);
    wr(24'h0, {8'h00, CMD_CLR_STAT});
    pgm_err <= 1'b0;
    n = reqs;
    wr(24'h020000, {8'h00, CMD_BUF_PGM});
    wr(24'h020000, 16'h0001);
    wr(24'h020000, 16'h4444);
    wr(24'h020001, 16'h5555);
    wr(24'h020000, {8'h00, CMD_CONFIRM});
    // First word ends clean, second word fails
    nfs_host_i.hold(50);
    pgm_err <= 1'b1;
    nfs_host_i.hold(70);
    `CHK("bufreqs", n + 2, reqs)
    `CHK("bufaddr", 24'h020001, o_pgm_addr)
    `CHK("bufdata", 16'h5555 & 16'hA5C2, o_pgm_data)
    st(8'h90);
    wr(24'h0, {8'h00, CMD_CLR_STAT});
    $display("buffered program done");
    wr(24'h000801, {8'h00, CMD_CFG_SETUP});
    wr(24'h000801, {8'h00, CMD_CFG_WRITE});
    for (int m = 0; m < 2; m++) begin
      wr(24'h0, {8'h00, m ? CMD_RD_IDENT : CMD_RD_ARRAY});
      nfs_host_i.burst(24'h000000, w);
      for (int k = 1; k < 5; k++)
        `CHK("burst", m ? 16'h1234 : 16'(k - 1) ^ 16'hA5C3, w[k])
    end
    $display("burst done");
    i_reset_n <= 1'b0;
    nfs_host_i.hold(4);
    i_reset_n <= 1'b1;
    nfs_host_i.hold(4);
    fork
      nfs_host_i.rd(24'h000033, q);
      begin
        nfs_host_i.hold(6);
        `CHK("oe_read", 1'b1, o_dq_oe)
      end
    join
    `CHK("rst_array", 16'hA5F0, q)
    $display("reset done");
    report_and_stop;
  end
endmodule // tb_top
